// *** eim_defines.vh ***
`ifndef EIM_DEFINES_VH
`define EIM_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses on the slave bus.
`define EIM_ADDR_W 8
`define EIM_ADDR_MASK_LO 8'h3C
`define EIM_ADDR_MASK_HI 8'h40
`define EIM_ADDR_STAT_LO 8'h44
`define EIM_ADDR_STAT_HI 8'h48
`define EIM_ADDR_CTRL 8'h50

////////////////////////////////////////////////////////////////////////////////
// Reset values and implemented status bits.
`define EIM_MASK_RST 32'h00000000
`define EIM_STAT_RST 32'h00000000
`define EIM_RDATA_RST 32'h00000000
`define EIM_LO_IMPL 32'h3FBE0000
`define EIM_HI_IMPL 32'h00001FF2

////////////////////////////////////////////////////////////////////////////////
// Field positions in the lower words.
`define EIM_LO_IRQ_FLAG 0
`define EIM_LO_FRAME_WAIT_TIMEOUT 17
`define EIM_LO_LEADING_EDGE_ERROR 18
`define EIM_LO_VOLTAGE_WARNING 19
`define EIM_LO_RECEIVER_OVERRUN 20
`define EIM_LO_PREAMBLE_TIMEOUT 21
`define EIM_LO_RESERVED 22
`define EIM_LO_LINK_READY 23
`define EIM_LO_SLOW_IDLE_ENTRY 24
`define EIM_LO_LOCK_LOSS_WARNING 25
`define EIM_LO_DELIMITER_TIMEOUT 26
`define EIM_LO_HALF_PERIOD_DELAY 27
`define EIM_LO_TIMESTAMP_SEQ_ERROR 28
`define EIM_LO_FILTER_REJECT 29

////////////////////////////////////////////////////////////////////////////////
// Field positions in the upper words.
`define EIM_HI_PREAMBLE_REJECT 1
`define EIM_HI_SUPPLY_TEMP_DRIFT 4
`define EIM_HI_PIN_CHANGE 5
`define EIM_HI_CIPHER_DONE 6
`define EIM_HI_CIPHER_ERROR 7
`define EIM_HI_COMMAND_ERROR 8
`define EIM_HI_LINK_OVERFLOW 9
`define EIM_HI_LINK_UNDERFLOW 10
`define EIM_HI_LINK_FAULT 11
`define EIM_HI_CHANNEL_ASSESS_FAIL 12

////////////////////////////////////////////////////////////////////////////////
// Control word fields.
`define EIM_CTRL_SOFT_RESET 0

`endif

// *** eim_event_latch.v ***
`timescale 1ns/1ps
`include "eim_defines.vh"

module eim_event_latch #(
  parameter W = 32,
  parameter [W-1:0] IMPL = {W{1'b1}}
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_soft_clear,
  input wire [W-1:0] i_set,
  input wire [W-1:0] i_clear,
  output reg [W-1:0] o_status_q
);

  ////////////////////////////////////////////////////////////////////////////
  // A set in the same cycle as a write-one clear wins, so no event is lost.
  // The soft reset is a device reset, so it overrides even a fresh event.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_status_q <= {W{1'b0}};
    end else if (i_soft_clear) begin
      o_status_q <= {W{1'b0}};
    end else begin
      o_status_q <= ((o_status_q & ~i_clear) | i_set) & IMPL; // RULE_23
    end
  end

endmodule

// *** eim_event_mask.v ***
`timescale 1ns/1ps
`include "eim_defines.vh"

// What this block does
// RULE_01: Frame wait timeout interrupts only when status and low mask bit 17 set.
// RULE_02: Leading edge error interrupts only while low mask bit 18 is one.
// RULE_03: Voltage warning interrupts only when its low mask enable and status set.
// RULE_04: Receiver overrun interrupts only with low mask bit 20 and status set.
// RULE_05: Preamble timeout gated onto the line by low mask bit 21.
// RULE_06: Soft reset may pulse the line with status already cleared.
// RULE_07: Link ready interrupts only with low mask bit 23 and status set.
// RULE_08: Entering slow-clock idle sets an event, gated by low mask bit 24.
// RULE_09: Lock loss warning interrupts only with low mask bit 25 and status set.
// RULE_10: Delimiter timeout interrupts only while its low mask enable is one.
// RULE_11: Half period delay warning gated by low mask bit 27.
// RULE_12: Timestamp sequence error gated by low mask bit 28.
// RULE_13: Frame filter rejection gated by low mask bit 29.
// RULE_14: Preamble rejection gated by high mask bit 1.
// RULE_15: Supply or temperature drift gated by high mask bit 4.
// RULE_16: Pin change interrupt gated by high mask bit 5.
// RULE_17: Cipher done gated by high bit 6, cipher error by bit 7.
// RULE_18: Command error gated by high mask bit 8.
// RULE_19: Link overflow gated by high bit 9, underflow by bit 10.
// RULE_20: Link fault gated by high mask bit 11.
// RULE_21: Channel assessment failure gated by high mask bit 12.
// RULE_22: Line active from one cycle after any enabled status bit is set until one cycle after none is.
// RULE_23: Status bits stay set until written with one or wiped by soft reset; zero leaves them.
// RULE_24: Reserved low mask bit 22 never affects the line.
module eim_event_mask (
  input wire I_CLK_SYS,
  input wire I_RESET,
  input wire [7:0] I_ADDRESS,
  input wire I_READ,
  input wire I_WRITE,
  input wire [31:0] I_WRITEDATA,
  input wire [3:0] I_BYTEENABLE,
  output reg [31:0] O_READDATA,
  output reg O_WAITREQUEST,
  input wire [31:0] I_EVENT_LO,
  input wire [31:0] I_EVENT_HI,
  input wire I_SLOW_IDLE_STATE,
  output reg O_IRQ,
  output reg O_SOFT_RESET
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  wire req;
  wire fire;
  wire wr_fire;
  wire [31:0] wmask;
  wire sel_mask_lo;
  wire sel_mask_hi;
  wire sel_stat_lo;
  wire sel_stat_hi;
  wire sel_ctrl;
  wire wr_mask_lo;
  wire wr_mask_hi;
  wire wr_stat_lo;
  wire wr_stat_hi;
  wire wr_ctrl;
  reg wait_d;
  reg [31:0] rdata_d;

  // Registers and event state.
  reg [31:0] mask_lo_q;
  reg [31:0] mask_lo_d;
  reg [31:0] mask_hi_q;
  reg [31:0] mask_hi_d;
  reg soft_reset_d;
  reg idle_q;
  reg irq_d;
  wire idle_entry;
  wire [31:0] set_lo;
  wire [31:0] set_hi;
  wire [31:0] clr_lo;
  wire [31:0] clr_hi;
  wire [31:0] stat_lo;
  wire [31:0] stat_hi;
  wire any_lo;
  wire any_hi;

  // Per-event interrupt requests after the mask.
  wire req_frame_wait_timeout;
  wire req_leading_edge_error;
  wire req_voltage_warning;
  wire req_receiver_overrun;
  wire req_preamble_timeout;
  wire req_link_ready;
  wire req_slow_idle_entry;
  wire req_lock_loss_warning;
  wire req_delimiter_timeout;
  wire req_half_period_delay;
  wire req_timestamp_seq_error;
  wire req_filter_reject;
  wire req_preamble_reject;
  wire req_supply_temp_drift;
  wire req_pin_change;
  wire req_cipher_done;
  wire req_cipher_error;
  wire req_command_error;
  wire req_link_overflow;
  wire req_link_underflow;
  wire req_link_fault;
  wire req_channel_assess_fail;

  ////////////////////////////////////////////////////////////////////////////
  // The slave holds waitrequest high while idle, drops it for one cycle after
  // seeing a request, and completes the access on the edge that sees it low.
  // This costs one wait cycle but keeps every output a plain flip-flop.
  assign req = I_READ | I_WRITE;
  assign fire = req & ~O_WAITREQUEST;
  assign wr_fire = fire & I_WRITE;
  // Byte enables apply to mask writes, status clears and the control word alike.
  assign wmask = {{8{I_BYTEENABLE[3]}}, {8{I_BYTEENABLE[2]}},
                  {8{I_BYTEENABLE[1]}}, {8{I_BYTEENABLE[0]}}};

  assign sel_mask_lo = (I_ADDRESS == `EIM_ADDR_MASK_LO);
  assign sel_mask_hi = (I_ADDRESS == `EIM_ADDR_MASK_HI);
  assign sel_stat_lo = (I_ADDRESS == `EIM_ADDR_STAT_LO);
  assign sel_stat_hi = (I_ADDRESS == `EIM_ADDR_STAT_HI);
  assign sel_ctrl = (I_ADDRESS == `EIM_ADDR_CTRL);

  // One write strobe per register, qualified by the completing edge only.
  assign wr_mask_lo = wr_fire & sel_mask_lo;
  assign wr_mask_hi = wr_fire & sel_mask_hi;
  assign wr_stat_lo = wr_fire & sel_stat_lo;
  assign wr_stat_hi = wr_fire & sel_stat_hi;
  assign wr_ctrl = wr_fire & sel_ctrl;

  always @* begin
    wait_d = ~(req & O_WAITREQUEST);
  end

  // Read data is captured when the request is first seen and stands at the
  // completion edge. Unmapped addresses read as zero.
  always @* begin
    rdata_d = O_READDATA;
    if (I_READ && O_WAITREQUEST) begin
      case (I_ADDRESS)
        `EIM_ADDR_MASK_LO: begin
          rdata_d = mask_lo_q;
        end
        `EIM_ADDR_MASK_HI: begin
          rdata_d = mask_hi_q;
        end
        `EIM_ADDR_STAT_LO: begin
          rdata_d = stat_lo;
          rdata_d[`EIM_LO_IRQ_FLAG] = O_IRQ;
        end
        `EIM_ADDR_STAT_HI: begin
          rdata_d = stat_hi;
        end
        default: begin
          rdata_d = `EIM_RDATA_RST;
        end
      endcase
    end
  end

  always @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_WAITREQUEST <= 1'b1;
      O_READDATA <= `EIM_RDATA_RST;
    end else begin
      O_WAITREQUEST <= wait_d;
      O_READDATA <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers, written with byte enables, cleared by soft reset.
  // Every bit is stored, so the reserved bit reads back what was written.
  always @* begin
    mask_lo_d = mask_lo_q;
    mask_hi_d = mask_hi_q;
    // Soft reset outranks a write in the same cycle, since the device restarts.
    if (O_SOFT_RESET) begin
      mask_lo_d = `EIM_MASK_RST;
      mask_hi_d = `EIM_MASK_RST;
    end else if (wr_mask_lo) begin
      mask_lo_d = (mask_lo_q & ~wmask) | (I_WRITEDATA & wmask);
    end else if (wr_mask_hi) begin
      mask_hi_d = (mask_hi_q & ~wmask) | (I_WRITEDATA & wmask);
    end
  end

  always @* begin
    soft_reset_d = wr_ctrl & I_BYTEENABLE[0] &
                   I_WRITEDATA[`EIM_CTRL_SOFT_RESET];
  end

  always @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      mask_lo_q <= `EIM_MASK_RST;
      mask_hi_q <= `EIM_MASK_RST;
      O_SOFT_RESET <= 1'b0;
    end else begin
      mask_lo_q <= mask_lo_d;
      mask_hi_q <= mask_hi_d;
      O_SOFT_RESET <= soft_reset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event capture. The idle tracker starts high so that a device already
  // idle at reset release does not report a false entry.
  always @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      idle_q <= 1'b1;
    end else begin
      idle_q <= I_SLOW_IDLE_STATE;
    end
  end

  // Bit 24 of the raw event word is replaced by the idle entry edge, so a
  // source wired there by mistake can never set the idle flag.
  assign idle_entry = I_SLOW_IDLE_STATE & ~idle_q; // RULE_08
  assign set_lo = {I_EVENT_LO[31:`EIM_LO_SLOW_IDLE_ENTRY + 1], idle_entry,
                   I_EVENT_LO[`EIM_LO_SLOW_IDLE_ENTRY - 1:0]};
  assign set_hi = I_EVENT_HI;

  // Writing one clears a status bit; writing zero leaves it.
  assign clr_lo = wr_stat_lo ? (I_WRITEDATA & wmask) : 32'h00000000; // RULE_23
  assign clr_hi = wr_stat_hi ? (I_WRITEDATA & wmask) : 32'h00000000; // RULE_23

  eim_event_latch #(
    .W(32),
    .IMPL(`EIM_LO_IMPL)
  ) u_latch_lo (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_soft_clear(O_SOFT_RESET),
    .i_set(set_lo),
    .i_clear(clr_lo),
    .o_status_q(stat_lo)
  );

  eim_event_latch #(
    .W(32),
    .IMPL(`EIM_HI_IMPL)
  ) u_latch_hi (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_soft_clear(O_SOFT_RESET),
    .i_set(set_hi),
    .i_clear(clr_hi),
    .o_status_q(stat_hi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gating of each latched event by its enable in the lower mask word.
  assign req_frame_wait_timeout = stat_lo[`EIM_LO_FRAME_WAIT_TIMEOUT] &
                                  mask_lo_q[`EIM_LO_FRAME_WAIT_TIMEOUT]; // RULE_01
  assign req_leading_edge_error = stat_lo[`EIM_LO_LEADING_EDGE_ERROR] &
                                  mask_lo_q[`EIM_LO_LEADING_EDGE_ERROR]; // RULE_02
  assign req_voltage_warning = stat_lo[`EIM_LO_VOLTAGE_WARNING] &
                               mask_lo_q[`EIM_LO_VOLTAGE_WARNING]; // RULE_03
  assign req_receiver_overrun = stat_lo[`EIM_LO_RECEIVER_OVERRUN] &
                                mask_lo_q[`EIM_LO_RECEIVER_OVERRUN]; // RULE_04
  assign req_preamble_timeout = stat_lo[`EIM_LO_PREAMBLE_TIMEOUT] &
                                mask_lo_q[`EIM_LO_PREAMBLE_TIMEOUT]; // RULE_05
  assign req_link_ready = stat_lo[`EIM_LO_LINK_READY] &
                          mask_lo_q[`EIM_LO_LINK_READY]; // RULE_07
  assign req_slow_idle_entry = stat_lo[`EIM_LO_SLOW_IDLE_ENTRY] &
                               mask_lo_q[`EIM_LO_SLOW_IDLE_ENTRY]; // RULE_08
  assign req_lock_loss_warning = stat_lo[`EIM_LO_LOCK_LOSS_WARNING] &
                                 mask_lo_q[`EIM_LO_LOCK_LOSS_WARNING]; // RULE_09
  assign req_delimiter_timeout = stat_lo[`EIM_LO_DELIMITER_TIMEOUT] &
                                 mask_lo_q[`EIM_LO_DELIMITER_TIMEOUT]; // RULE_10
  assign req_half_period_delay = stat_lo[`EIM_LO_HALF_PERIOD_DELAY] &
                                 mask_lo_q[`EIM_LO_HALF_PERIOD_DELAY]; // RULE_11
  assign req_timestamp_seq_error = stat_lo[`EIM_LO_TIMESTAMP_SEQ_ERROR] &
                                   mask_lo_q[`EIM_LO_TIMESTAMP_SEQ_ERROR]; // RULE_12
  assign req_filter_reject = stat_lo[`EIM_LO_FILTER_REJECT] &
                             mask_lo_q[`EIM_LO_FILTER_REJECT]; // RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // Gating of each latched event by its enable in the upper mask word.
  assign req_preamble_reject = stat_hi[`EIM_HI_PREAMBLE_REJECT] &
                               mask_hi_q[`EIM_HI_PREAMBLE_REJECT]; // RULE_14
  assign req_supply_temp_drift = stat_hi[`EIM_HI_SUPPLY_TEMP_DRIFT] &
                                 mask_hi_q[`EIM_HI_SUPPLY_TEMP_DRIFT]; // RULE_15
  assign req_pin_change = stat_hi[`EIM_HI_PIN_CHANGE] &
                          mask_hi_q[`EIM_HI_PIN_CHANGE]; // RULE_16
  assign req_cipher_done = stat_hi[`EIM_HI_CIPHER_DONE] &
                           mask_hi_q[`EIM_HI_CIPHER_DONE]; // RULE_17
  assign req_cipher_error = stat_hi[`EIM_HI_CIPHER_ERROR] &
                            mask_hi_q[`EIM_HI_CIPHER_ERROR]; // RULE_17
  assign req_command_error = stat_hi[`EIM_HI_COMMAND_ERROR] &
                             mask_hi_q[`EIM_HI_COMMAND_ERROR]; // RULE_18
  assign req_link_overflow = stat_hi[`EIM_HI_LINK_OVERFLOW] &
                             mask_hi_q[`EIM_HI_LINK_OVERFLOW]; // RULE_19
  assign req_link_underflow = stat_hi[`EIM_HI_LINK_UNDERFLOW] &
                              mask_hi_q[`EIM_HI_LINK_UNDERFLOW]; // RULE_19
  assign req_link_fault = stat_hi[`EIM_HI_LINK_FAULT] &
                          mask_hi_q[`EIM_HI_LINK_FAULT]; // RULE_20
  assign req_channel_assess_fail = stat_hi[`EIM_HI_CHANNEL_ASSESS_FAIL] &
                                   mask_hi_q[`EIM_HI_CHANNEL_ASSESS_FAIL]; // RULE_21

  ////////////////////////////////////////////////////////////////////////////
  // The line is the registered OR of all enabled requests. The reserved mask
  // bit is deliberately absent from this sum.
  assign any_lo = req_frame_wait_timeout | // RULE_22
                  req_leading_edge_error |
                  req_voltage_warning |
                  req_receiver_overrun |
                  req_preamble_timeout | // RULE_24
                  req_link_ready |
                  req_slow_idle_entry |
                  req_lock_loss_warning |
                  req_delimiter_timeout |
                  req_half_period_delay |
                  req_timestamp_seq_error |
                  req_filter_reject;

  // Upper word bits without an event of their own stay out of the sum.
  assign any_hi = req_preamble_reject | // RULE_22
                  req_supply_temp_drift |
                  req_pin_change |
                  req_cipher_done |
                  req_cipher_error |
                  req_command_error |
                  req_link_overflow |
                  req_link_underflow |
                  req_link_fault |
                  req_channel_assess_fail;

  always @* begin
    irq_d = any_lo | any_hi; // RULE_22
  end

  // The line lags the status by one cycle. On a soft reset it can therefore
  // stay active for one cycle after the status has already been wiped, which
  // the host must tolerate as an interrupt with nothing set.
  always @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= irq_d; // RULE_06
    end
  end

endmodule

// *** eim_event_mask_properties.sv ***
`timescale 1ns/1ps
module eim_event_mask_props (
  input wire I_CLK_SYS,
  input wire I_RESET,
  input wire [7:0] I_ADDRESS,
  input wire I_READ,
  input wire I_WRITE,
  input wire [31:0] I_WRITEDATA,
  input wire [31:0] I_EVENT_LO,
  input wire [31:0] I_EVENT_HI,
  input wire I_SLOW_IDLE_STATE,
  input wire [31:0] O_READDATA,
  input wire O_WAITREQUEST,
  input wire O_IRQ,
  input wire O_SOFT_RESET
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);
  //////////////////////////////////////////////////////////////////////////////
  property p_wait_ack;
    (I_READ || I_WRITE) && O_WAITREQUEST |=> !O_WAITREQUEST;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("request not answered");
  property p_wait_one;
    !O_WAITREQUEST |=> O_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  // Control reads zero as well, so it shares the unmapped check.
  property p_unmapped;
    I_READ && O_WAITREQUEST && !(I_ADDRESS inside {8'h3C, 8'h40, 8'h44, 8'h48})
      |=> O_READDATA == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold;
    !I_READ |=> $stable(O_READDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_srst_cause;
    $rose(O_SOFT_RESET) |-> $past(I_WRITE && I_ADDRESS == 8'h50 && I_WRITEDATA[0]);
  endproperty
  a_srst_cause: assert property (p_srst_cause) else $error("soft reset without write");
  property p_srst_pulse;
    O_SOFT_RESET |=> !O_SOFT_RESET;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse too long");
  property p_srst_wipe;
    O_SOFT_RESET |=> ##1 !O_IRQ;
  endproperty
  a_srst_wipe: assert property (p_srst_wipe) else $error("line high after wipe");
  property p_irq_rise;
    $rose(O_IRQ) |-> $past(I_WRITE, 2) || $past(|I_EVENT_LO, 2) || $past(|I_EVENT_HI, 2)
      || $past(I_SLOW_IDLE_STATE, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("line rose without cause");
  property p_irq_fall;
    $fell(O_IRQ) |-> $past(I_WRITE, 2) || $past(O_SOFT_RESET) || $past(O_SOFT_RESET, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("line fell without clear");
endmodule
bind eim_event_mask eim_event_mask_props i_eim_event_mask_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
  .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA), .I_EVENT_LO(I_EVENT_LO),
  .I_EVENT_HI(I_EVENT_HI), .I_SLOW_IDLE_STATE(I_SLOW_IDLE_STATE),
  .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST), .O_IRQ(O_IRQ),
  .O_SOFT_RESET(O_SOFT_RESET));

// *** eim_host_model.sv ***
`timescale 1ns/1ps
module eim_host_model (
  input wire i_clk,
  input wire i_reset,
  input wire i_irq,
  output logic [7:0] o_rise_cnt
);
  logic irq_q;
  // A rise that finds no status set after a soft reset is only counted, never flagged.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_q <= 1'b0;
      o_rise_cnt <= 8'h00;
    end else begin
      irq_q <= i_irq;
      if (i_irq && !irq_q) begin
        o_rise_cnt <= o_rise_cnt + 8'h01;
      end
    end
  end
endmodule

// *** eim_event_mask_tb.sv ***
`timescale 1ns/1ps
`include "eim_defines.vh"
module eim_event_mask_tb;
  logic I_CLK_SYS = 1'b0;
  logic I_RESET = 1'b1;
  logic [7:0] I_ADDRESS = 8'h00;
  logic I_READ = 1'b0;
  logic I_WRITE = 1'b0;
  logic [31:0] I_WRITEDATA = 32'h00000000;
  logic [3:0] I_BYTEENABLE = 4'hF;
  logic [31:0] I_EVENT_LO = 32'h00000000;
  logic [31:0] I_EVENT_HI = 32'h00000000;
  logic I_SLOW_IDLE_STATE = 1'b0;
  wire [31:0] O_READDATA;
  wire O_WAITREQUEST;
  wire O_IRQ;
  wire O_SOFT_RESET;
  wire [7:0] rise_cnt;
  logic [31:0] exp_q[$];
  logic [31:0] v;
  logic [31:0] m;
  logic [7:0] ma;
  logic [7:0] sa;
  logic hi;
  int b;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int srst_cnt = 0;
  int seed = 87;
  int lob[12] = '{17, 18, 19, 20, 21, 23, 24, 25, 26, 27, 28, 29};
  int hib[10] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12};
  eim_event_mask i_eim_event_mask (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
    .I_ADDRESS(I_ADDRESS), .I_READ(I_READ), .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA),
    .I_BYTEENABLE(I_BYTEENABLE), .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST),
    .I_EVENT_LO(I_EVENT_LO), .I_EVENT_HI(I_EVENT_HI), .I_SLOW_IDLE_STATE(I_SLOW_IDLE_STATE),
    .O_IRQ(O_IRQ), .O_SOFT_RESET(O_SOFT_RESET));
  eim_host_model i_eim_host_model (.i_clk(I_CLK_SYS), .i_reset(I_RESET), .i_irq(O_IRQ),
    .o_rise_cnt(rise_cnt));
  always #25 I_CLK_SYS = ~I_CLK_SYS;
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // The request stands until the rising edge that samples waitrequest low. One idle
  // edge follows, so a second call never reassigns a strobe in the same time step.
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    I_ADDRESS <= a;
    I_WRITEDATA <= d;
    I_WRITE <= we;
    I_READ <= !we;
    @(posedge I_CLK_SYS);
    while (O_WAITREQUEST !== 1'b0) @(posedge I_CLK_SYS);
    I_WRITE <= 1'b0;
    I_READ <= 1'b0;
    @(posedge I_CLK_SYS);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask
  task ev(input logic h, input int n);
    if (h) I_EVENT_HI <= 32'h00000001 << n;
    else if (n == 24) I_SLOW_IDLE_STATE <= 1'b1;
    else I_EVENT_LO <= 32'h00000001 << n;
    @(posedge I_CLK_SYS);
    I_EVENT_HI <= 32'h00000000;
    I_EVENT_LO <= 32'h00000000;
    I_SLOW_IDLE_STATE <= 1'b0;
  endtask
  task irq_is(input logic e);
    repeat (3) @(posedge I_CLK_SYS);
    @(negedge I_CLK_SYS);
    chk({31'h00000000, O_IRQ}, {31'h00000000, e});
    @(posedge I_CLK_SYS);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge I_CLK_SYS) begin
    if (O_SOFT_RESET === 1'b1) srst_cnt++;
    if (I_READ === 1'b1 && O_WAITREQUEST === 1'b0) begin
      chk(O_READDATA, exp_q.pop_front());
    end
  end
  always @(posedge I_CLK_SYS) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(posedge I_CLK_SYS);
    I_RESET <= 1'b0;
    @(posedge I_CLK_SYS);
    rd(`EIM_ADDR_MASK_LO, 32'h00000000);
    rd(`EIM_ADDR_MASK_HI, 32'h00000000);
    rd(`EIM_ADDR_STAT_LO, 32'h00000000);
    rd(`EIM_ADDR_STAT_HI, 32'h00000000);
    bus(1'b1, 8'h4C, 32'hFFFFFFFF);
    rd(8'h4C, 32'h00000000);
    rd(8'h3D, 32'h00000000);
    rd(`EIM_ADDR_CTRL, 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      ma = k[0] ? `EIM_ADDR_MASK_HI : `EIM_ADDR_MASK_LO;
      bus(1'b1, ma, v);
      rd(ma, v);
      bus(1'b1, ma, 32'h00000000);
    end
    I_BYTEENABLE <= 4'h5;
    bus(1'b1, `EIM_ADDR_MASK_LO, 32'hFFFFFFFF);
    I_BYTEENABLE <= 4'hF;
    rd(`EIM_ADDR_MASK_LO, 32'h00FF00FF);
    bus(1'b1, `EIM_ADDR_MASK_LO, 32'h00400000);
    I_EVENT_LO <= 32'hFFFFFFFF;
    @(posedge I_CLK_SYS);
    I_EVENT_LO <= 32'h00000000;
    irq_is(1'b0);
    rd(`EIM_ADDR_STAT_LO, `EIM_LO_IMPL & 32'hFEFFFFFF);
    bus(1'b1, `EIM_ADDR_STAT_LO, 32'hFFFFFFFF);
    bus(1'b1, `EIM_ADDR_MASK_LO, 32'h00000000);
    rd(`EIM_ADDR_STAT_LO, 32'h00000000);
    for (int i = 0; i < 22; i++) begin
      hi = (i >= 12);
      if (hi) b = hib[i - 12];
      else b = lob[i];
      m = 32'h00000001 << b;
      ma = hi ? `EIM_ADDR_MASK_HI : `EIM_ADDR_MASK_LO;
      sa = hi ? `EIM_ADDR_STAT_HI : `EIM_ADDR_STAT_LO;
      ev(hi, b);
      irq_is(1'b0);
      bus(1'b1, ma, m);
      if (hi) irq_is(1'b1);
      else if (b < 24) irq_is(1'b1);
      else irq_is(1'b1);
      bus(1'b1, sa, 32'h00000000);
      irq_is(1'b1);
      rd(sa, hi ? m : (m | 32'h00000001));
      bus(1'b1, sa, m);
      irq_is(1'b0);
      bus(1'b1, ma, 32'h00000000);
    end
    bus(1'b1, `EIM_ADDR_MASK_LO, 32'h00200000);
    ev(1'b0, 21);
    irq_is(1'b1);
    bus(1'b1, `EIM_ADDR_CTRL, 32'h00000001);
    irq_is(1'b0);
    rd(`EIM_ADDR_MASK_LO, 32'h00000000);
    rd(`EIM_ADDR_STAT_LO, 32'h00000000);
    chk({24'h000000, rise_cnt}, 32'h00000017);
    chk(srst_cnt, 32'h00000001);
    finish_test;
  end
endmodule
